// *** src/rivp_pkg.sv ***
// Behaviour
// - With the boot reset fuse unprogrammed, every kind of system reset enters at word 0x000.
// - Each vector is one instruction word, so consecutive vector numbers sit at consecutive words.
// - External requests 0 and 1 sit at 0x001 and 0x002, pin-change groups 0 to 2 at 0x003 to 0x005.
// - The watchdog vector sits at 0x006 and timer 2 compare A, compare B, overflow at 0x007 to 0x009.
// - Timer 1 capture, compare A, compare B and overflow sit at 0x00a to 0x00d.
// - Timer 0 compare A, compare B and overflow sit at 0x00e, 0x00f and 0x010.
// - The SPI vector sits at 0x011 and the USART receive, data empty, transmit at 0x012 to 0x014.
// - ADC, EEPROM ready, comparator, two-wire unit and store ready sit at 0x015 to 0x019.
// - With the boot reset fuse programmed (0), execution starts after any reset at the boot reset address.
// - With the table select set, every interrupt vector address is its base address plus the boot section start.
// - The table starts one word above the boot reset address when selected, else at 0x001, whatever the fuse.
package rivp_pkg;

	// Program word address width for the smaller flash (4K words).
	localparam int ADDR_W = 12;
	localparam int VNUM_W = 5;
	// Interrupt sources are vectors 2 to 26; request bit i belongs to vector i + 2.
	localparam int NUM_IRQ = 25;
	localparam logic [VNUM_W-1:0] VEC_FIRST_IRQ = 5'h02;

	// Reset entry and the word step between table slots.
	localparam logic [ADDR_W-1:0] RESET_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] VEC_STEP = 12'h001;
	localparam logic [ADDR_W-1:0] APP_BASE = 12'h000;

	// Vector numbers.
	localparam logic [VNUM_W-1:0] VEC_RESET = 5'h01;
	localparam logic [VNUM_W-1:0] VEC_EXT0 = 5'h02;
	localparam logic [VNUM_W-1:0] VEC_PCG2 = 5'h06;
	localparam logic [VNUM_W-1:0] VEC_WDOG = 5'h07;
	localparam logic [VNUM_W-1:0] VEC_T2OVF = 5'h0a;
	localparam logic [VNUM_W-1:0] VEC_T1CAP = 5'h0b;
	localparam logic [VNUM_W-1:0] VEC_T1OVF = 5'h0e;
	localparam logic [VNUM_W-1:0] VEC_T0CMA = 5'h0f;
	localparam logic [VNUM_W-1:0] VEC_T0OVF = 5'h11;
	localparam logic [VNUM_W-1:0] VEC_SPI = 5'h12;
	localparam logic [VNUM_W-1:0] VEC_UTX = 5'h15;
	localparam logic [VNUM_W-1:0] VEC_ADC = 5'h16;
	localparam logic [VNUM_W-1:0] VEC_SPMRDY = 5'h1a;

	// Application table addresses of the same vectors.
	localparam logic [ADDR_W-1:0] VADDR_EXT0 = 12'h001;
	localparam logic [ADDR_W-1:0] VADDR_PCG2 = 12'h005;
	localparam logic [ADDR_W-1:0] VADDR_WDOG = 12'h006;
	localparam logic [ADDR_W-1:0] VADDR_T2OVF = 12'h009;
	localparam logic [ADDR_W-1:0] VADDR_T1CAP = 12'h00a;
	localparam logic [ADDR_W-1:0] VADDR_T1OVF = 12'h00d;
	localparam logic [ADDR_W-1:0] VADDR_T0CMA = 12'h00e;
	localparam logic [ADDR_W-1:0] VADDR_T0OVF = 12'h010;
	localparam logic [ADDR_W-1:0] VADDR_SPI = 12'h011;
	localparam logic [ADDR_W-1:0] VADDR_UTX = 12'h014;
	localparam logic [ADDR_W-1:0] VADDR_ADC = 12'h015;
	localparam logic [ADDR_W-1:0] VADDR_SPMRDY = 12'h019;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_RESET,
		ST_IDLE,
		ST_GAP
	} rivp_state_type;

endpackage : rivp_pkg

// *** src/rivp_prio_enc.sv ***
`timescale 1ns/1ps
// Lowest-index-wins priority encoder.
module rivp_prio_enc #(
	parameter int WIDTH = 25,
	parameter int IDX_W = 5
) (
	// Request vector
	input wire logic [WIDTH-1:0] req,
	// Winner
	output logic [IDX_W-1:0] idx,
	output logic any
);

	// Scan from the top down so the lowest set bit is the last to win.
	always_comb begin
		idx = '0;
		any = 1'b0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = IDX_W'(i);
				any = 1'b1;
			end
		end
	end

endmodule : rivp_prio_enc

// *** src/rivp_vector_gen.sv ***
`timescale 1ns/1ps
// Reset and interrupt vector address generator for the instruction fetch unit.
module rivp_vector_gen
	import rivp_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Fuse, control bit and boot section start
	input wire logic boot_reset_fuse,
	input wire logic vector_table_select,
	input wire logic [ADDR_W-1:0] boot_reset_addr,
	// Pending requests from the sources and acceptance from the core
	input wire logic [NUM_IRQ-1:0] irq_req,
	input wire logic int_accept,
	// Fetch redirect to the core
	output logic fetch_valid_ff,
	output logic [ADDR_W-1:0] fetch_addr_ff,
	output logic [VNUM_W-1:0] vector_num_ff,
	output logic is_reset_ff,
	// Acknowledge to the served source, lets it clear its flag
	output logic [NUM_IRQ-1:0] irq_ack_ff
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	rivp_state_type state_ff;
	rivp_state_type nxt_state;
	logic tbl_sel_ff;
	logic [VNUM_W-1:0] win_idx;
	logic win_any;
	wire [VNUM_W-1:0] win_vec;
	wire [ADDR_W-1:0] tbl_base;
	wire [ADDR_W-1:0] irq_addr;
	wire [ADDR_W-1:0] rst_addr;
	wire [NUM_IRQ-1:0] win_onehot;
	wire serve_irq;
	wire serve_rst;

	////////////////////////////////////////////////////////////////////////////
	// Selection

	rivp_prio_enc #(
		.WIDTH(NUM_IRQ),
		.IDX_W(VNUM_W)
	) rivp_prio_enc_i (
		.req(irq_req),
		.idx(win_idx),
		.any(win_any)
	);

	// Winner's vector number and its one-hot acknowledge.
	assign win_vec = win_idx + VEC_FIRST_IRQ;
	assign win_onehot = NUM_IRQ'(1) << win_idx;

	// Table base is zero or the boot section start; the fuse plays no part here.
	assign tbl_base = vector_table_select ? boot_reset_addr : APP_BASE;
	// One word per vector, so slot = base + number - 1.
	assign irq_addr = tbl_base + {{(ADDR_W-VNUM_W){1'b0}}, win_vec} - VEC_STEP;
	// A programmed fuse (0) moves the reset entry into the boot section.
	assign rst_addr = boot_reset_fuse ? RESET_ADDR : boot_reset_addr;

	assign serve_rst = (state_ff == ST_RESET);
	assign serve_irq = (state_ff == ST_IDLE) && int_accept && win_any;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	// The gap state gives the served source one cycle to drop its request, so
	// the same flag is never taken twice; the cost is one idle cycle per entry.
	always_comb begin
		case (state_ff)
			ST_RESET: nxt_state = ST_IDLE;
			ST_IDLE: nxt_state = serve_irq ? ST_GAP : ST_IDLE;
			ST_GAP: nxt_state = ST_IDLE;
			default: nxt_state = ST_RESET;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_ff <= ST_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Redirect pulse: reset entry once after reset, then accepted interrupts.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			fetch_valid_ff <= 1'b0;
			is_reset_ff <= 1'b0;
			tbl_sel_ff <= 1'b0;
		end else begin
			fetch_valid_ff <= serve_rst || serve_irq;
			is_reset_ff <= serve_rst;
			tbl_sel_ff <= vector_table_select;
		end
	end

	// Address and number hold until the next redirect.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			fetch_addr_ff <= RESET_ADDR;
			vector_num_ff <= VEC_RESET;
		end else if (serve_rst) begin
			fetch_addr_ff <= rst_addr;
			vector_num_ff <= VEC_RESET;
		end else if (serve_irq) begin
			fetch_addr_ff <= irq_addr;
			vector_num_ff <= win_vec;
		end
	end

	// Acknowledge is a one-cycle pulse aligned with the redirect.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_ack_ff <= '0;
		end else begin
			irq_ack_ff <= serve_irq ? win_onehot : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_rst_release;
		$past(sys_rst) ##0 !sys_rst;
	endsequence

	sequence s_irq_taken;
		state_ff == ST_IDLE ##0 int_accept ##0 (|irq_req);
	endsequence

	sequence s_app_fetch(logic [VNUM_W-1:0] v);
		fetch_valid_ff && !is_reset_ff && !tbl_sel_ff && vector_num_ff == v;
	endsequence

	a_reset_app_entry: assert property (
		s_rst_release ##0 boot_reset_fuse |=> fetch_valid_ff && is_reset_ff
			&& fetch_addr_ff == RESET_ADDR)
		else $error("Reset entry with fuse clear is not word zero.");

	a_reset_boot_entry: assert property (
		s_rst_release ##0 !boot_reset_fuse |=> fetch_valid_ff && is_reset_ff
			&& fetch_addr_ff == $past(boot_reset_addr))
		else $error("Reset entry with fuse programmed is not the boot address.");

	a_one_word_step: assert property (
		fetch_valid_ff && !is_reset_ff && !tbl_sel_ff |->
			fetch_addr_ff == {{(ADDR_W-VNUM_W){1'b0}}, vector_num_ff} - VEC_STEP)
		else $error("Application vector is not one word per number.");

	a_ext_pin_slots: assert property (
		s_app_fetch(VEC_EXT0) or s_app_fetch(VEC_PCG2) |->
			fetch_addr_ff == (vector_num_ff == VEC_EXT0 ? VADDR_EXT0 : VADDR_PCG2))
		else $error("External or pin-change vector misplaced.");

	a_wdog_t2_slots: assert property (
		s_app_fetch(VEC_WDOG) or s_app_fetch(VEC_T2OVF) |->
			fetch_addr_ff == (vector_num_ff == VEC_WDOG ? VADDR_WDOG : VADDR_T2OVF))
		else $error("Watchdog or timer 2 vector misplaced.");

	a_t1_slots: assert property (
		s_app_fetch(VEC_T1CAP) or s_app_fetch(VEC_T1OVF) |->
			fetch_addr_ff == (vector_num_ff == VEC_T1CAP ? VADDR_T1CAP : VADDR_T1OVF))
		else $error("Timer 1 vector misplaced.");

	a_t0_slots: assert property (
		s_app_fetch(VEC_T0CMA) or s_app_fetch(VEC_T0OVF) |->
			fetch_addr_ff == (vector_num_ff == VEC_T0CMA ? VADDR_T0CMA : VADDR_T0OVF))
		else $error("Timer 0 vector misplaced.");

	a_serial_slots: assert property (
		s_app_fetch(VEC_SPI) or s_app_fetch(VEC_UTX) |->
			fetch_addr_ff == (vector_num_ff == VEC_SPI ? VADDR_SPI : VADDR_UTX))
		else $error("SPI or USART vector misplaced.");

	a_misc_slots: assert property (
		s_app_fetch(VEC_ADC) or s_app_fetch(VEC_SPMRDY) |->
			fetch_addr_ff == (vector_num_ff == VEC_ADC ? VADDR_ADC : VADDR_SPMRDY))
		else $error("ADC or store-ready vector misplaced.");

	a_boot_table: assert property (
		s_irq_taken ##0 vector_table_select |=> fetch_valid_ff &&
			fetch_addr_ff == $past(boot_reset_addr) + {{(ADDR_W-VNUM_W){1'b0}}, vector_num_ff}
			- VEC_STEP)
		else $error("Boot table vector is not boot start plus slot.");

	a_accept_fetch: assert property (
		s_irq_taken |=> fetch_valid_ff && !is_reset_ff ##1 !fetch_valid_ff)
		else $error("Accepted interrupt did not give a single redirect pulse.");

	// The number reported must name the acknowledged source, not the encoder's own index.
	a_lowest_first: assert property (
		s_irq_taken |=> irq_ack_ff == ($past(irq_req) & (~$past(irq_req) + NUM_IRQ'(1)))
			&& irq_ack_ff == (NUM_IRQ'(1) << (vector_num_ff - VEC_FIRST_IRQ)))
		else $error("Served request is not the lowest pending one.");

	// Exactly one source is told it was served, or two flags would clear at once.
	a_ack_onehot: assert property (
		fetch_valid_ff && !is_reset_ff |-> $onehot(irq_ack_ff))
		else $error("Interrupt redirect does not acknowledge exactly one source.");

	// The reset entry clears no source flag and always reports vector one.
	a_reset_no_ack: assert property (
		is_reset_ff |-> fetch_valid_ff && irq_ack_ff == '0 && vector_num_ff == VEC_RESET)
		else $error("Reset entry acknowledged a source or named another vector.");

	// Without an accepted pending request there is no redirect after reset entry.
	a_refused_idle: assert property (
		state_ff != ST_RESET && !(int_accept && (|irq_req)) |=> !fetch_valid_ff)
		else $error("Redirect without an accepted pending request.");

	// Address and number only move with a redirect; the reset release is excluded.
	a_addr_holds: assert property (
		!fetch_valid_ff && !$past(sys_rst) |-> $stable(fetch_addr_ff)
			&& $stable(vector_num_ff))
		else $error("Fetch address or number changed without a redirect.");

	// With the select clear the table starts at word one, whatever the fuse holds.
	a_app_table: assert property (
		s_irq_taken ##0 !vector_table_select |=> fetch_valid_ff &&
			fetch_addr_ff == {{(ADDR_W-VNUM_W){1'b0}}, vector_num_ff} - VEC_STEP)
		else $error("Application table vector is not word one plus slot.");

endmodule : rivp_vector_gen

// *** sim/rivp_core_model.sv ***
`timescale 1ns/1ps
// Interrupt sources and core acceptance, as the fetch unit sees them.
module rivp_core_model
	import rivp_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Bench control
	input wire logic [NUM_IRQ-1:0] raise_req,
	input wire logic accept_en,
	// Design side
	input wire logic [NUM_IRQ-1:0] irq_ack_ff,
	output logic [NUM_IRQ-1:0] irq_req,
	output logic int_accept
);
	logic [NUM_IRQ-1:0] pend_ff;
	logic [NUM_IRQ-1:0] nxt_pend;
	////////////////////////////////////////////////////////////////////////////////
	// A flag drops on its acknowledge, so it is gone by the end of the gap cycle.
	assign nxt_pend = (pend_ff & ~irq_ack_ff) | raise_req;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pend_ff <= '0;
		end else begin
			pend_ff <= nxt_pend;
		end
	end
	// Acceptance only while software has interrupts enabled.
	assign int_accept = accept_en;
	assign irq_req = pend_ff;
endmodule : rivp_core_model

// *** sim/reset_irq_vector_placement_bench.sv ***
`timescale 1ns/1ps
module reset_irq_vector_placement_bench
	import rivp_pkg::*;
;
	localparam logic [ADDR_W-1:0] BOOT_ADDR = 12'hc00;
	logic core_clk, sys_rst, boot_reset_fuse, vector_table_select, accept_en, int_accept;
	logic [ADDR_W-1:0] boot_reset_addr, fetch_addr_ff;
	logic [NUM_IRQ-1:0] raise_req, irq_req, irq_ack_ff;
	logic fetch_valid_ff, is_reset_ff;
	logic [VNUM_W-1:0] vector_num_ff;
	int err_total = 0;
	int n_tests = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Design and the core model beside it.
	rivp_vector_gen rivp_vector_gen_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.boot_reset_fuse(boot_reset_fuse), .vector_table_select(vector_table_select),
		.boot_reset_addr(boot_reset_addr), .irq_req(irq_req), .int_accept(int_accept),
		.fetch_valid_ff(fetch_valid_ff), .fetch_addr_ff(fetch_addr_ff),
		.vector_num_ff(vector_num_ff), .is_reset_ff(is_reset_ff), .irq_ack_ff(irq_ack_ff));
	rivp_core_model rivp_core_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.raise_req(raise_req), .accept_en(accept_en), .irq_ack_ff(irq_ack_ff),
		.irq_req(irq_req), .int_accept(int_accept));
	// Free-running core clock at 100 ns.
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers; all driving and sampling happens 1 ns after the rising edge.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask : tick
	// A bounded wait, so a design that never redirects ends the run.
	task automatic wait_fetch;
		int k;
		k = 0;
		while (fetch_valid_ff !== 1'b1) begin
			tick();
			k++;
			if (k > 20) begin
				check(32'h0, 32'h1, "fetch timeout");
				complete_run();
			end
		end
	endtask : wait_fetch
	task automatic raise(input logic [NUM_IRQ-1:0] mask);
		raise_req = mask;
		tick();
		raise_req = '0;
	endtask : raise
	// Checks one serve, then that the gap cycle ignores the still-raised accept.
	task automatic serve(input int vec, input logic [ADDR_W-1:0] exp);
		logic [NUM_IRQ-1:0] hot;
		hot = '0;
		hot[vec-2] = 1'b1;
		wait_fetch();
		check(fetch_addr_ff, exp, "vector address");
		check(vector_num_ff, vec, "vector number");
		check(irq_ack_ff, hot, "served source");
		check(is_reset_ff, 1'b0, "interrupt not reset");
		tick();
		check(fetch_valid_ff, 1'b0, "gap cycle");
	endtask : serve
	////////////////////////////////////////////////////////////////////////////////
	// Reset entry for a given fuse setting.
	task automatic scen_reset(input logic fuse, input logic [ADDR_W-1:0] exp);
		boot_reset_fuse = fuse;
		sys_rst = 1'b1;
		repeat (3) tick();
		sys_rst = 1'b0;
		wait_fetch();
		check(is_reset_ff, 1'b1, "reset flag");
		check(fetch_addr_ff, exp, "reset entry");
		check(vector_num_ff, 5'h01, "reset vector");
		tick();
		check(fetch_valid_ff, 1'b0, "reset pulse ends");
		check(is_reset_ff, 1'b0, "reset flag ends");
	endtask : scen_reset
	// Every source alone, walking the whole table at the chosen base.
	task automatic scen_table(input logic sel, input logic [ADDR_W-1:0] base);
		vector_table_select = sel;
		accept_en = 1'b1;
		for (int v = 2; v <= 26; v++) begin
			raise(NUM_IRQ'(1) << (v - 2));
			serve(v, 12'(base + v - 1));
			check(fetch_addr_ff, 12'(base + v - 1), "table slot");
		end
		accept_en = 1'b0;
	endtask : scen_table
	// No request means no redirect; three raised together leave lowest first.
	task automatic scen_priority;
		vector_table_select = 1'b0;
		accept_en = 1'b1;
		repeat (3) tick();
		check(fetch_valid_ff, 1'b0, "accept without request");
		accept_en = 1'b0;
		raise(25'h1000021);
		repeat (3) tick();
		check(fetch_valid_ff, 1'b0, "request without accept");
		accept_en = 1'b1;
		serve(2, 12'h001);
		serve(7, 12'h006);
		serve(26, 12'h019);
		accept_en = 1'b0;
	endtask : scen_priority
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		sys_rst = 1'b1;
		boot_reset_fuse = 1'b1;
		vector_table_select = 1'b0;
		boot_reset_addr = BOOT_ADDR;
		raise_req = '0;
		accept_en = 1'b0;
		scen_reset(1'b1, 12'h000);
		scen_table(1'b0, 12'h000);
		scen_priority();
		scen_reset(1'b0, BOOT_ADDR);
		scen_table(1'b1, BOOT_ADDR);
		scen_table(1'b0, 12'h000);
		scen_reset(1'b1, 12'h000);
		scen_table(1'b1, BOOT_ADDR);
		complete_run();
	end
endmodule : reset_irq_vector_placement_bench
